// >>> rtl/paging_pkg.sv
// Overview of operation
// - page select at CAh, write only
// - two page bits pick lower 2K page
// - interrupts and calls leave page select unchanged
// - page select not initialised at reset
// - readout protection blocks external program reads
// - protection cleared only by full erasure
// - data 40h-7Fh reads program memory window
// - window address is base then low six bits
// - window moves in 64-byte steps
// - window register write only, no read path
// - window register not cleared, load before use
// - two RAM and two EEPROM banks at 00h-3Fh
// - six 12-bit return address stack entries
// - program counter is 12 bits wide
// - pc bit 11 selects static page
// - window base in seven low bits
package paging_pkg;
  localparam int PC_W = 12;
  localparam int PROG_ADDR_W = 13;
  localparam int DATA_ADDR_W = 8;
  localparam int STACK_DEPTH = 6;
  localparam int STACK_PTR_W = 3;
  localparam int BANK_ADDR_W = 6;
  localparam int BANK_WORDS = 64;
  localparam int WIN_BASE_W = 7;
  localparam int PAGE_W = 2;
  localparam logic [7:0] PAGE_SEL_ADDR = 8'hca;
  localparam logic [7:0] WINDOW_ADDR = 8'hc9;
  localparam logic [7:0] BANK_SEL_ADDR = 8'hcb;
  localparam logic [7:0] WIN_LO_ADDR = 8'h40;
  localparam logic [7:0] WIN_HI_ADDR = 8'h7f;
  localparam logic [7:0] BANK_HI_ADDR = 8'h3f;
  localparam int PC_STATIC_BIT = 11;
  localparam logic [1:0] STATIC_PAGE = 2'h1;
  localparam int BANK_EE0_BIT = 0;
  localparam int BANK_EE1_BIT = 1;
  localparam int BANK_RAM1_BIT = 3;
  localparam int BANK_RAM2_BIT = 4;
  localparam logic [1:0] BANK_RAM1 = 2'h0;
  localparam logic [1:0] BANK_RAM2 = 2'h1;
  localparam logic [1:0] BANK_EE0 = 2'h2;
  localparam logic [1:0] BANK_EE1 = 2'h3;
  localparam int BANK_COUNT = 4;
  typedef enum logic [1:0] {
    PROT_OPEN,
    PROT_LOCKED,
    PROT_ERASING
  } prot_state_t;
endpackage

// >>> rtl/bank_mem.sv
module bank_mem
  import paging_pkg::*;
(
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [BANK_ADDR_W-1:0] addr_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem [BANK_WORDS];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[addr_in] <= wr_data_in;
    end
  end

  assign rd_data_out = mem[addr_in];
endmodule

// >>> rtl/return_stack.sv
module return_stack
  import paging_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [PC_W-1:0] push_pc_in,
  output logic [PC_W-1:0] top_pc_out,
  output logic full_out,
  output logic empty_out
);
  logic [PC_W-1:0] entry [STACK_DEPTH];
  logic [STACK_PTR_W-1:0] depth_reg;
  logic [STACK_PTR_W-1:0] depth_next;
  logic do_push;
  logic do_pop;

  assign full_out = (depth_reg == STACK_PTR_W'(STACK_DEPTH));
  assign empty_out = (depth_reg == '0);
  assign do_push = push_in && !full_out;
  assign do_pop = pop_in && !empty_out && !push_in;
  assign depth_next = do_push ? depth_reg + 3'h1 :
                      do_pop ? depth_reg - 3'h1 : depth_reg;
  assign top_pc_out = empty_out ? '0 : entry[depth_reg - 3'h1];

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      depth_reg <= '0;
    end else begin
      depth_reg <= depth_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (do_push) begin
      entry[depth_reg] <= push_pc_in;
    end
  end
endmodule

// >>> rtl/program_data_paging.sv
module program_data_paging
  import paging_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  // data-space access from the core
  input wire logic data_wr_in,
  input wire logic data_rd_in,
  input wire logic bit_op_in,
  input wire logic [DATA_ADDR_W-1:0] data_addr_in,
  input wire logic [7:0] data_wr_data_in,
  output logic [7:0] data_rd_data_out,
  output logic data_hit_out,
  output logic reg_misuse_out,
  // fetch side
  input wire logic [PC_W-1:0] pc_in,
  input wire logic call_in,
  input wire logic return_in,
  output logic [PC_W-1:0] return_pc_out,
  output logic stack_full_out,
  output logic stack_empty_out,
  // program memory port
  output logic [PROG_ADDR_W-1:0] prog_addr_out,
  input wire logic [7:0] prog_data_in,
  output logic win_read_out,
  // external readout and protection option
  input wire logic ext_rd_in,
  input wire logic [PROG_ADDR_W-1:0] ext_addr_in,
  output logic [7:0] ext_data_out,
  output logic ext_blocked_out,
  input wire logic protect_set_in,
  input wire logic full_erase_in,
  output logic erase_all_out,
  output logic protected_out
);
  // ****************************************
  // address decode
  // ****************************************
  logic page_wr;
  logic window_wr;
  logic bank_wr;
  logic in_window;
  logic in_bank;
  logic wo_touch;

  assign page_wr = data_wr_in && !bit_op_in &&
                   (data_addr_in == PAGE_SEL_ADDR);
  assign window_wr = data_wr_in && !bit_op_in &&
                     (data_addr_in == WINDOW_ADDR);
  assign bank_wr = data_wr_in && !bit_op_in &&
                   (data_addr_in == BANK_SEL_ADDR);
  assign in_window = (data_addr_in >= WIN_LO_ADDR) &&
                     (data_addr_in <= WIN_HI_ADDR);
  assign in_bank = (data_addr_in <= BANK_HI_ADDR);
  assign wo_touch = (data_addr_in == PAGE_SEL_ADDR) ||
                    (data_addr_in == WINDOW_ADDR) ||
                    (data_addr_in == BANK_SEL_ADDR);

  // ****************************************
  // write-only mapping registers
  // ****************************************
  logic [PAGE_W-1:0] page_sel_reg;
  logic [WIN_BASE_W-1:0] data_window_base_reg;
  logic [BANK_COUNT-1:0] bank_sel_reg;
  logic [BANK_COUNT-1:0] bank_sel_next;

  assign bank_sel_next = {data_wr_data_in[BANK_EE1_BIT],
                          data_wr_data_in[BANK_EE0_BIT],
                          data_wr_data_in[BANK_RAM2_BIT],
                          data_wr_data_in[BANK_RAM1_BIT]};

  // only a data write changes it
  always_ff @(posedge clk_in) begin
    if (page_wr) begin
      page_sel_reg <= data_wr_data_in[PAGE_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (window_wr) begin
      data_window_base_reg <= data_wr_data_in[WIN_BASE_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (bank_wr) begin
      bank_sel_reg <= bank_sel_next;
    end
  end

  // ****************************************
  // program address formation
  // ****************************************
  logic [PAGE_W-1:0] fetch_page;
  logic [PROG_ADDR_W-1:0] fetch_addr;
  logic [PROG_ADDR_W-1:0] window_addr;
  logic ext_go;

  // pc bit 11 forces static page
  assign fetch_page = pc_in[PC_STATIC_BIT] ? STATIC_PAGE : page_sel_reg;
  assign fetch_addr = {fetch_page, pc_in[PC_STATIC_BIT-1:0]};
  assign window_addr = {data_window_base_reg,
                        data_addr_in[BANK_ADDR_W-1:0]};
  assign win_read_out = data_rd_in && in_window;
  assign prog_addr_out = win_read_out ? window_addr :
                         ext_go ? ext_addr_in : fetch_addr;

  // ****************************************
  // banked RAM and EEPROM
  // ****************************************
  logic [7:0] bank_rd [BANK_COUNT];
  logic bank_any;
  logic [7:0] bank_data;

  genvar gi;
  generate
    for (gi = 0; gi < BANK_COUNT; gi++) begin : g_bank
      bank_mem u_bank (
        .clk_in(clk_in),
        .wr_en_in(data_wr_in && in_bank && bank_sel_reg[gi]),
        .addr_in(data_addr_in[BANK_ADDR_W-1:0]),
        .wr_data_in(data_wr_data_in),
        .rd_data_out(bank_rd[gi])
      );
    end
  endgenerate

  assign bank_any = |bank_sel_reg;

  always_comb begin
    bank_data = 8'h00;
    for (int i = 0; i < BANK_COUNT; i++) begin
      if (bank_sel_reg[i]) begin
        bank_data = bank_data | bank_rd[i];
      end
    end
  end

  // ****************************************
  // data read return
  // ****************************************
  logic [7:0] rd_data_next;
  logic hit_next;

  // window data same cycle as ram
  assign rd_data_next = in_window ? prog_data_in :
                        (in_bank && bank_any) ? bank_data : 8'h00;
  assign hit_next = data_rd_in && (in_window || (in_bank && bank_any));

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      data_rd_data_out <= 8'h00;
      data_hit_out <= 1'b0;
      reg_misuse_out <= 1'b0;
    end else begin
      data_rd_data_out <= data_rd_in ? rd_data_next : 8'h00;
      data_hit_out <= hit_next;
      reg_misuse_out <= wo_touch && (data_rd_in || bit_op_in);
    end
  end

  // ****************************************
  // return stack
  // ****************************************
  return_stack u_stack (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .push_in(call_in),
    .pop_in(return_in),
    .push_pc_in(pc_in),
    .top_pc_out(return_pc_out),
    .full_out(stack_full_out),
    .empty_out(stack_empty_out)
  );

  // ****************************************
  // readout protection
  // ****************************************
  prot_state_t prot_reg;
  prot_state_t prot_next;

  always_comb begin
    prot_next = prot_reg;
    case (prot_reg)
      PROT_OPEN: begin
        if (full_erase_in) begin
          prot_next = PROT_ERASING;
        end else if (protect_set_in) begin
          prot_next = PROT_LOCKED;
        end
      end
      PROT_LOCKED: begin
        if (full_erase_in) begin
          prot_next = PROT_ERASING;
        end
      end
      PROT_ERASING: begin
        if (!full_erase_in) begin
          prot_next = PROT_OPEN;
        end
      end
      default: begin
        prot_next = PROT_LOCKED;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      prot_reg <= PROT_LOCKED;
    end else begin
      prot_reg <= prot_next;
    end
  end

  logic locked;
  assign locked = (prot_reg != PROT_OPEN);
  assign protected_out = locked;
  assign erase_all_out = (prot_reg == PROT_ERASING);
  assign ext_blocked_out = ext_rd_in && locked;
  assign ext_go = ext_rd_in && !locked;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ext_data_out <= 8'h00;
    end else if (ext_go && !win_read_out) begin
      ext_data_out <= prog_data_in;
    end else begin
      ext_data_out <= 8'h00;
    end
  end
endmodule

// >>> test/program_data_paging_monitor.sv
module program_data_paging_monitor
  import paging_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic data_wr_in,
  input wire logic data_rd_in,
  input wire logic bit_op_in,
  input wire logic [DATA_ADDR_W-1:0] data_addr_in,
  input wire logic [7:0] data_wr_data_in,
  input wire logic [7:0] data_rd_data_out,
  input wire logic data_hit_out,
  input wire logic reg_misuse_out,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic call_in,
  input wire logic [PC_W-1:0] return_pc_out,
  input wire logic stack_full_out,
  input wire logic [PROG_ADDR_W-1:0] prog_addr_out,
  input wire logic [7:0] prog_data_in,
  input wire logic win_read_out,
  input wire logic ext_rd_in,
  input wire logic [PROG_ADDR_W-1:0] ext_addr_in,
  input wire logic [7:0] ext_data_out,
  input wire logic ext_blocked_out,
  input wire logic protect_set_in,
  input wire logic full_erase_in,
  input wire logic erase_all_out,
  input wire logic protected_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // port checks
  // ****************************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire logic win_a = data_addr_in[7:6] == 2'h1;
  wire logic cfg_a = data_addr_in == PAGE_SEL_ADDR ||
                     data_addr_in == WINDOW_ADDR;
  property p_win_addr;
    data_rd_in && win_a |-> win_read_out &&
      prog_addr_out[5:0] == data_addr_in[5:0];
  endproperty
  a_win_addr: assert property (p_win_addr)
    else $error("window address mismatch");
  property p_win_data;
    data_rd_in && win_a |=> data_hit_out &&
      data_rd_data_out == $past(prog_data_in);
  endproperty
  a_win_data: assert property (p_win_data)
    else $error("window read data mismatch");
  property p_misuse;
    data_rd_in && cfg_a |=> reg_misuse_out && data_rd_data_out == 8'h00;
  endproperty
  a_misuse: assert property (p_misuse)
    else $error("write-only read not refused");
  property p_static;
    !win_read_out && !(ext_rd_in && !protected_out) &&
      pc_in[PC_STATIC_BIT] |->
      prog_addr_out == {STATIC_PAGE, pc_in[10:0]};
  endproperty
  a_static: assert property (p_static)
    else $error("static page fetch address bad");
  property p_page_set;
    (data_wr_in && !bit_op_in && data_addr_in == PAGE_SEL_ADDR) ##1
      (!win_read_out && !(ext_rd_in && !protected_out) &&
      !pc_in[PC_STATIC_BIT]) |->
      prog_addr_out[12:11] == $past(data_wr_data_in[1:0]);
  endproperty
  a_page_set: assert property (p_page_set)
    else $error("page select not applied");
  property p_push;
    call_in && !stack_full_out |=> return_pc_out == $past(pc_in);
  endproperty
  a_push: assert property (p_push)
    else $error("pushed address not on top");
  property p_ext;
    ext_rd_in && protected_out |-> ext_blocked_out ##1 ext_data_out == 8'h00;
  endproperty
  a_ext: assert property (p_ext)
    else $error("protected readout not blocked");
  property p_ext_addr;
    ext_rd_in && !protected_out && !win_read_out |->
      prog_addr_out == ext_addr_in;
  endproperty
  a_ext_addr: assert property (p_ext_addr)
    else $error("open readout address not routed");
  property p_erase;
    full_erase_in ##1 (!full_erase_in && !protect_set_in) |->
      erase_all_out ##1 !protected_out;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase did not clear protection");
  c_win: cover property (data_rd_in && win_a);
  c_full: cover property (stack_full_out);
  c_erase: cover property (erase_all_out);
endmodule

// >>> test/prog_mem_model.sv
module prog_mem_model
  import paging_pkg::*;
(
  input wire logic [PROG_ADDR_W-1:0] addr_in,
  output logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // each address gives a byte formed from its bits, in the same cycle
  assign data_out = addr_in[7:0] ^ {addr_in[12:8], 3'h5};
endmodule

// >>> test/program_data_paging_tb.sv
module program_data_paging_tb;
  import paging_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic data_wr_in = 1'b0, data_rd_in = 1'b0, bit_op_in = 1'b0;
  logic call_in = 1'b0, return_in = 1'b0, ext_rd_in = 1'b0;
  logic protect_set_in = 1'b0, full_erase_in = 1'b0;
  logic [7:0] data_addr_in = 8'h00, data_wr_data_in = 8'h00;
  logic [11:0] pc_in = 12'h800;
  logic [12:0] ext_addr_in = 13'h0000, prog_addr_out, pa;
  logic [7:0] data_rd_data_out, ext_data_out, prog_data_in, d;
  logic [11:0] return_pc_out;
  logic data_hit_out, reg_misuse_out, stack_full_out, stack_empty_out;
  logic win_read_out, ext_blocked_out, erase_all_out, protected_out, h, m;
  int fail_count = 0, n_checks = 0;
  always #2.5 clk_in = ~clk_in;
  program_data_paging uut (
    .clk_in, .reset_in, .data_wr_in, .data_rd_in, .bit_op_in,
    .data_addr_in, .data_wr_data_in, .data_rd_data_out, .data_hit_out,
    .reg_misuse_out, .pc_in, .call_in, .return_in, .return_pc_out,
    .stack_full_out, .stack_empty_out, .prog_addr_out, .prog_data_in,
    .win_read_out, .ext_rd_in, .ext_addr_in, .ext_data_out,
    .ext_blocked_out, .protect_set_in, .full_erase_in, .erase_all_out,
    .protected_out
  );
  prog_mem_model mem_u (.addr_in(prog_addr_out), .data_out(prog_data_in));
  // ****************************************
  // bus tasks
  // ****************************************
  function automatic logic [7:0] mem(input logic [12:0] a);
    return a[7:0] ^ {a[12:8], 3'h5};
  endfunction
  task automatic chk(input logic [15:0] g, e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // strobes stay up so that accesses can run back to back
  task automatic wr(input logic [7:0] a, v, input logic b = 1'b0);
    data_rd_in = 1'b0;
    data_wr_in = 1'b1;
    bit_op_in = b;
    data_addr_in = a;
    data_wr_data_in = v;
    @(negedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a);
    data_wr_in = 1'b0;
    data_rd_in = 1'b1;
    data_addr_in = a;
    #1 pa = prog_addr_out;
    @(negedge clk_in);
    d = data_rd_data_out;
    h = data_hit_out;
    m = reg_misuse_out;
  endtask
  task automatic idle;
    data_wr_in = 1'b0;
    data_rd_in = 1'b0;
    bit_op_in = 1'b0;
    @(negedge clk_in);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_prot;
    chk(protected_out, 1'b1);
    ext_rd_in = 1'b1;
    #1 chk(ext_blocked_out, 1'b1);
    @(negedge clk_in);
    chk(ext_data_out, 8'h00);
    ext_rd_in = 1'b0;
    full_erase_in = 1'b1;
    @(negedge clk_in);
    full_erase_in = 1'b0;
    chk(erase_all_out, 1'b1);
    @(negedge clk_in);
    chk(protected_out, 1'b0);
    ext_rd_in = 1'b1;
    ext_addr_in = 13'h1234;
    #1 chk(ext_blocked_out, 1'b0);
    @(negedge clk_in);
    chk(ext_data_out, mem(13'h1234));
    ext_rd_in = 1'b0;
    protect_set_in = 1'b1;
    @(negedge clk_in);
    protect_set_in = 1'b0;
    chk(protected_out, 1'b1);
    $display("protection test done");
  endtask
  task automatic t_page;
    wr(BANK_SEL_ADDR, 8'h08);
    // page changes made from the static page, shadow first
    for (int p = 0; p < 4; p++) begin
      wr(8'h00, 8'(p));
      wr(PAGE_SEL_ADDR, 8'hfc | 8'(p));
      pc_in = 12'h123;
      #1 chk(prog_addr_out, {2'(p), 11'h123});
      @(negedge clk_in);
      pc_in = 12'h923;
      #1 chk(prog_addr_out, {STATIC_PAGE, 11'h123});
      @(negedge clk_in);
    end
    rd(8'h00);
    chk({h, d}, 9'h103);
    wr(PAGE_SEL_ADDR, 8'h00, 1'b1);
    idle;
    pc_in = 12'h123;
    call_in = 1'b1;
    @(negedge clk_in);
    call_in = 1'b0;
    chk(return_pc_out, 12'h123);
    return_in = 1'b1;
    @(negedge clk_in);
    return_in = 1'b0;
    chk(prog_addr_out, {2'h3, 11'h123});
    rd(PAGE_SEL_ADDR);
    chk({m, d}, 9'h100);
    rd(WINDOW_ADDR);
    chk({m, d}, 9'h100);
    $display("page test done");
  endtask
  task automatic t_window;
    wr(WINDOW_ADDR, 8'h28);
    rd(8'h59);
    chk(pa, 13'h0a19);
    chk({h, d}, {1'b1, mem(13'h0a19)});
    wr(WINDOW_ADDR, 8'hff);
    rd(8'h7f);
    chk(pa, 13'h1fff);
    chk(d, mem(13'h1fff));
    wr(WINDOW_ADDR, 8'h01);
    rd(8'h40);
    chk(pa, 13'h0040);
    idle;
    $display("window test done");
  endtask
  task automatic t_bank;
    logic [7:0] sel [4] = '{8'h01, 8'h02, 8'h08, 8'h10};
    for (int i = 0; i < 4; i++) begin
      wr(BANK_SEL_ADDR, sel[i]);
      wr(8'h3f, sel[i] ^ 8'h5a);
    end
    for (int i = 0; i < 4; i++) begin
      wr(BANK_SEL_ADDR, sel[i]);
      rd(8'h3f);
      chk({h, d}, {1'b1, sel[i] ^ 8'h5a});
    end
    wr(BANK_SEL_ADDR, 8'h00);
    rd(8'h3f);
    chk({h, d}, 9'h000);
    idle;
    $display("bank test done");
  endtask
  task automatic t_stack;
    for (int i = 1; i <= 7; i++) begin
      pc_in = 12'(i);
      call_in = 1'b1;
      @(negedge clk_in);
    end
    call_in = 1'b0;
    chk(stack_full_out, 1'b1);
    for (int i = 6; i >= 1; i--) begin
      chk(return_pc_out, 12'(i));
      return_in = 1'b1;
      @(negedge clk_in);
    end
    return_in = 1'b0;
    chk(stack_empty_out, 1'b1);
    $display("stack test done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk_in);
    reset_in = 1'b0;
    t_prot;
    t_page;
    t_window;
    t_bank;
    t_stack;
    test_done;
  end
  initial begin
    #20us;
    fail_count++;
    test_done;
  end
endmodule
bind program_data_paging program_data_paging_monitor mon (
  .clk_in, .reset_in, .data_wr_in, .data_rd_in, .bit_op_in, .data_addr_in,
  .data_wr_data_in, .data_rd_data_out, .data_hit_out, .reg_misuse_out,
  .pc_in, .call_in, .return_pc_out, .stack_full_out, .prog_addr_out,
  .prog_data_in, .win_read_out, .ext_rd_in, .ext_addr_in, .ext_data_out,
  .ext_blocked_out, .protect_set_in, .full_erase_in, .erase_all_out,
  .protected_out
);
